// ---- hdl/sdma_top.sv ----
// eight transfer channels between serial ports and memory
`timescale 1ns/1ps
`include "sdma_consts.svh"
module sdma_top (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // register access forwarded from the ports' windows
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [31:0] reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    output logic      [31:0] reg_rdata_o,
    // port side: 0..2 serial, 3 spi
    input  wire logic [3:0]  item_half_i,
    input  wire logic [3:0]  rx_rdy_i,
    input  wire logic [63:0] rx_data_i,
    output logic      [3:0]  rx_take_o,
    input  wire logic [3:0]  tx_empty_i,
    output logic      [15:0] tx_data_o,
    output logic      [3:0]  tx_load_o,
    output logic      [3:0]  rx_end_o,
    output logic      [3:0]  tx_end_o,
    // memory master
    output logic             mem_req_o,
    output logic             mem_we_o,
    output logic      [31:0] mem_addr_o,
    output logic      [3:0]  mem_be_o,
    output logic      [31:0] mem_wdata_o,
    input  wire logic        mem_gnt_i,
    input  wire logic [31:0] mem_rdata_i
);
    localparam logic [3:0][31:0] BASES = {`SDMA_BASE_SPI, `SDMA_BASE_SER2,
                                          `SDMA_BASE_SER1, `SDMA_BASE_SER0};

    sdma_pkg::sdma_top_s q, d;

    logic [7:0][31:0] ch_ptr;
    logic [7:0][15:0] ch_cnt;
    logic [7:0]       ch_en;
    logic [7:0]       ch_act;
    logic [7:0]       ch_done;
    logic [7:0]       ld_ptr;
    logic [7:0]       ld_cnt;
    logic [7:0]       en_set;
    logic [7:0]       en_clr;
    logic [7:0]       step;
    logic [7:0]       req;
    logic [3:0]       win_hit;
    logic [13:0]      ofs;
    logic [31:0]      rd_sh;

    // channel 2p serves receive of port p, 2p+1 its transmit
    genvar gc;
    generate
        for (gc = 0; gc < `SDMA_NCH; gc++) begin : g_ch
            sdma_chan u_chan (
                .clk_i    (clk_i),
                .rst_i    (rst_i),
                .ld_ptr_i (ld_ptr[gc]),
                .ld_cnt_i (ld_cnt[gc]),
                .wdata_i  (reg_wdata_i),
                .en_set_i (en_set[gc]),
                .en_clr_i (en_clr[gc]),
                .step_i   (step[gc]),
                .half_i   (item_half_i[gc/2]),
                .ptr_o    (ch_ptr[gc]),
                .cnt_o    (ch_cnt[gc]),
                .en_o     (ch_en[gc]),
                .active_o (ch_act[gc]),
                .done_o   (ch_done[gc])
            );
            // a transmit port just loaded may still show empty for a cycle
            if (gc % 2 == 0) begin : g_rx
                assign req[gc] = ch_act[gc] && rx_rdy_i[gc/2];
            end else begin : g_tx
                assign req[gc] = ch_act[gc] && tx_empty_i[gc/2] && !q.tx_load[gc/2];
            end
        end
    endgenerate

    // window decode: 16K windows above the peripheral floor, base is lowest address
    always_comb begin
        ofs = reg_addr_i[13:0];
        for (int p = 0; p < `SDMA_NPER; p++) begin
            win_hit[p] = reg_addr_i >= `SDMA_PERIPH_FLOOR &&
                         reg_addr_i[31:`SDMA_WIN_LSB] == BASES[p][31:`SDMA_WIN_LSB];
        end
    end

    // pointer, count and enable writes land on the owning port's channels
    always_comb begin
        ld_ptr = '0;
        ld_cnt = '0;
        en_set = '0;
        en_clr = '0;
        for (int p = 0; p < `SDMA_NPER; p++) begin
            if (reg_wr_i && win_hit[p]) begin
                ld_ptr[2*p]   = ofs == `SDMA_OFS_RX_PTR;
                ld_cnt[2*p]   = ofs == `SDMA_OFS_RX_CNT;
                ld_ptr[2*p+1] = ofs == `SDMA_OFS_TX_PTR;
                ld_cnt[2*p+1] = ofs == `SDMA_OFS_TX_CNT;
                en_set[2*p]   = ofs == `SDMA_OFS_EN_SET && reg_wdata_i[`SDMA_EN_RX_BIT];
                en_set[2*p+1] = ofs == `SDMA_OFS_EN_SET && reg_wdata_i[`SDMA_EN_TX_BIT];
                en_clr[2*p]   = ofs == `SDMA_OFS_EN_CLR && reg_wdata_i[`SDMA_EN_RX_BIT];
                en_clr[2*p+1] = ofs == `SDMA_OFS_EN_CLR && reg_wdata_i[`SDMA_EN_TX_BIT];
            end
        end
    end

    // little-endian read lane: lowest address byte sits in bits 7:0
    assign rd_sh = mem_rdata_i >> {q.addr[1:0], 3'b000};

    // arbiter and memory sequencer, one item in flight at a time
    always_comb begin
        logic       found;
        logic [2:0] idx;
        logic [1:0] pp;
        found     = 1'b0;
        idx       = 3'h0;
        pp        = 2'h0;
        d         = q;
        d.tx_load = 4'h0;
        d.rdata   = 32'h00000000;
        step      = 8'h00;
        rx_take_o = 4'h0;
        case (q.st)
            sdma_pkg::ST_IDLE: begin
                // round robin from the channel after the last served
                for (int k = 1; k <= `SDMA_NCH; k++) begin
                    idx = 3'(q.last + 3'(k));
                    if (!found && req[idx]) begin
                        found  = 1'b1;
                        d.cur  = idx;
                    end
                end
                if (found) begin
                    pp     = d.cur[2:1];
                    d.last = d.cur;
                    d.we   = !d.cur[0];
                    d.addr = ch_ptr[d.cur];
                    d.half = item_half_i[pp];
                    d.st   = sdma_pkg::ST_MEM;
                    if (!d.cur[0]) begin
                        rx_take_o[pp] = 1'b1;
                        d.wdata = item_half_i[pp] ? {2{rx_data_i[16*pp +: 16]}}
                                                  : {4{rx_data_i[16*pp +: 8]}};
                    end
                end
            end
            sdma_pkg::ST_MEM: begin
                if (mem_gnt_i) begin
                    step[q.cur] = 1'b1;
                    if (!q.we) begin
                        d.tx_data            = q.half ? rd_sh[15:0] : {8'h00, rd_sh[7:0]};
                        d.tx_load[q.cur[2:1]] = 1'b1;
                    end
                    d.st = sdma_pkg::ST_IDLE;
                end
            end
            default: d.st = sdma_pkg::ST_IDLE;
        endcase
        // read side of the window: pointers, counts and stored enables
        for (int p = 0; p < `SDMA_NPER; p++) begin
            if (reg_rd_i && win_hit[p]) begin
                case (ofs)
                    `SDMA_OFS_RX_PTR:  d.rdata = ch_ptr[2*p];
                    `SDMA_OFS_RX_CNT:  d.rdata = {16'h0000, ch_cnt[2*p]};
                    `SDMA_OFS_TX_PTR:  d.rdata = ch_ptr[2*p+1];
                    `SDMA_OFS_TX_CNT:  d.rdata = {16'h0000, ch_cnt[2*p+1]};
                    `SDMA_OFS_EN_STAT: d.rdata = {30'h00000000, ch_en[2*p+1], ch_en[2*p]};
                    default:           d.rdata = 32'h00000000;
                endcase
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '{st: sdma_pkg::ST_IDLE, cur: 3'h0, last: 3'h7, we: 1'b0, half: 1'b0,
                   addr: `SDMA_PTR_RST, wdata: 32'h00000000, tx_data: 16'h0000,
                   tx_load: 4'h0, rdata: 32'h00000000};
        end else begin
            q <= d;
        end
    end

    // byte enables follow the low address bits, little-endian
    assign mem_be_o    = q.half ? (q.addr[1] ? 4'hC : 4'h3) : 4'(4'h1 << q.addr[1:0]);
    assign mem_req_o   = q.st == sdma_pkg::ST_MEM;
    assign mem_we_o    = q.we;
    assign mem_addr_o  = q.addr;
    assign mem_wdata_o = q.wdata;
    assign tx_data_o   = q.tx_data;
    assign tx_load_o   = q.tx_load;
    assign reg_rdata_o = q.rdata;
    assign tx_end_o    = {ch_done[7], ch_done[5], ch_done[3], ch_done[1]};
    assign rx_end_o    = {ch_done[6], ch_done[4], ch_done[2], ch_done[0]};

    AST_RX_NEEDS_DATA: assert property (@(posedge clk_i) disable iff (rst_i)
        rx_take_o != 4'h0 |-> (rx_take_o & rx_rdy_i) == rx_take_o && !mem_req_o)
        else $error("receive item taken without data");
    AST_TX_AFTER_READ: assert property (@(posedge clk_i) disable iff (rst_i)
        tx_load_o != 4'h0 |-> $past(mem_req_o && mem_gnt_i && !mem_we_o))
        else $error("transmit load without a memory read");
    AST_REQ_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        mem_req_o && !mem_gnt_i |=> mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o))
        else $error("memory request dropped or changed before grant");
    AST_REQ_END: assert property (@(posedge clk_i) disable iff (rst_i)
        mem_req_o && mem_gnt_i |=> !mem_req_o)
        else $error("request not released after grant");
    AST_BYTE_LANE: assert property (@(posedge clk_i) disable iff (rst_i)
        mem_req_o && !q.half |-> mem_be_o == (4'h1 << mem_addr_o[1:0]) &&
        (!mem_we_o || mem_wdata_o[7:0] == mem_wdata_o[31:24]))
        else $error("byte lane is not little-endian");
    AST_PTR_TO_BUS: assert property (@(posedge clk_i) disable iff (rst_i)
        !mem_req_o ##1 mem_req_o |-> mem_addr_o == $past(ch_ptr[d.cur]))
        else $error("memory address is not the channel pointer");
endmodule : sdma_top

// ---- hdl/sdma_consts.svh ----
// constants for the serial peripheral transfer channels
// Summary of operation
// - eight transfer channels serve three serial ports and one SPI port.
// - each served port owns one receive channel and one transmit channel.
// - each channel holds a 32-bit address pointer and 16-bit count.
// - the owning port is told, by an end flag, when its channel finishes.
// - up to 64K contiguous items of one or two bytes move from one start address.
// - channels move data between ports and memory without processor help.
// - pointer and count are programmed through the owning port's register window.
// - each port window is 16K bytes inside the top 3M of address space.
// - a port's base address is the lowest address of its window.
// - the channel enable appears at set, clear and read addresses.
// - writing one sets or clears that bit; writing zero leaves it unchanged.
// - memory accesses use little-endian byte lanes.
`ifndef SDMA_CONSTS_SVH
`define SDMA_CONSTS_SVH

`define SDMA_NPER         4
`define SDMA_NCH          8
`define SDMA_PTR_W        32
`define SDMA_CNT_W        16
`define SDMA_WIN_LSB      14
`define SDMA_PERIPH_FLOOR 32'hFFD00000
`define SDMA_BASE_SER0    32'hFFFC0000
`define SDMA_BASE_SER1    32'hFFFC4000
`define SDMA_BASE_SER2    32'hFFFC8000
`define SDMA_BASE_SPI     32'hFFFBC000
`define SDMA_OFS_RX_PTR   14'h0030
`define SDMA_OFS_RX_CNT   14'h0034
`define SDMA_OFS_TX_PTR   14'h0038
`define SDMA_OFS_TX_CNT   14'h003C
`define SDMA_OFS_EN_SET   14'h0040
`define SDMA_OFS_EN_CLR   14'h0044
`define SDMA_OFS_EN_STAT  14'h0048
`define SDMA_EN_RX_BIT    0
`define SDMA_EN_TX_BIT    1
`define SDMA_PTR_RST      32'h00000000
`define SDMA_CNT_RST      16'h0000

`endif

// ---- hdl/sdma_pkg.sv ----
// types shared by the transfer channel files
`include "sdma_consts.svh"
package sdma_pkg;
    typedef enum logic {ST_IDLE, ST_MEM} sdma_state_e;

    typedef struct packed {
        logic [`SDMA_PTR_W-1:0] ptr;
        logic [`SDMA_CNT_W-1:0] cnt;
        logic                   en;
    } sdma_chan_s;

    typedef struct packed {
        sdma_state_e            st;
        logic [2:0]             cur;
        logic [2:0]             last;
        logic                   we;
        logic                   half;
        logic [`SDMA_PTR_W-1:0] addr;
        logic [31:0]            wdata;
        logic [15:0]            tx_data;
        logic [3:0]             tx_load;
        logic [31:0]            rdata;
    } sdma_top_s;
endpackage : sdma_pkg

// ---- hdl/sdma_chan.sv ----
// one transfer channel: pointer, count and enable
`timescale 1ns/1ps
`include "sdma_consts.svh"
module sdma_chan (
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire logic                   ld_ptr_i,
    input  wire logic                   ld_cnt_i,
    input  wire logic [31:0]            wdata_i,
    input  wire logic                   en_set_i,
    input  wire logic                   en_clr_i,
    input  wire logic                   step_i,
    input  wire logic                   half_i,
    output logic      [`SDMA_PTR_W-1:0] ptr_o,
    output logic      [`SDMA_CNT_W-1:0] cnt_o,
    output logic                        en_o,
    output logic                        active_o,
    output logic                        done_o
);
    sdma_pkg::sdma_chan_s q, d;

    // loads from the port window win over a step in the same cycle
    always_comb begin
        d = q;
        if (step_i && q.cnt != `SDMA_CNT_RST) begin
            d.ptr = q.ptr + (half_i ? 32'h00000002 : 32'h00000001);
            d.cnt = q.cnt - 16'h0001;
        end
        if (ld_ptr_i) d.ptr = wdata_i;
        if (ld_cnt_i) d.cnt = wdata_i[15:0];
        if (en_set_i) d.en = 1'b1;
        if (en_clr_i) d.en = 1'b0;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '{ptr: `SDMA_PTR_RST, cnt: `SDMA_CNT_RST, en: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign ptr_o    = q.ptr;
    assign cnt_o    = q.cnt;
    assign en_o     = q.en;
    assign active_o = q.en && q.cnt != `SDMA_CNT_RST;
    assign done_o   = q.en && q.cnt == `SDMA_CNT_RST;

    AST_PTR_ADV: assert property (@(posedge clk_i) disable iff (rst_i)
        step_i && !ld_ptr_i && q.cnt != 16'h0000 |=>
        ptr_o == $past(ptr_o) + ($past(half_i) ? 32'h00000002 : 32'h00000001))
        else $error("pointer did not advance by item size");
    AST_CNT_DEC: assert property (@(posedge clk_i) disable iff (rst_i)
        step_i && !ld_cnt_i && q.cnt != 16'h0000 |=> cnt_o == $past(cnt_o) - 16'h0001)
        else $error("count did not drop by one");
    AST_ZERO_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        q.cnt == 16'h0000 && !ld_cnt_i && !ld_ptr_i |=> cnt_o == 16'h0000 && $stable(ptr_o))
        else $error("exhausted channel moved");
    AST_EN_SET: assert property (@(posedge clk_i) disable iff (rst_i)
        en_set_i && !en_clr_i |=> en_o)
        else $error("enable not set");
    AST_EN_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
        en_clr_i && !en_set_i |=> !en_o)
        else $error("enable not cleared");
    AST_EN_KEEP: assert property (@(posedge clk_i) disable iff (rst_i)
        !en_set_i && !en_clr_i |=> en_o == $past(en_o))
        else $error("enable changed without a one written");
endmodule : sdma_chan

// ---- tb/sdma_mem_model.sv ----
// memory partner: little-endian byte array that grants after a chosen delay
`timescale 1ns/1ps
module sdma_mem_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        req_i,
    input  wire logic        we_i,
    input  wire logic [31:0] addr_i,
    input  wire logic [3:0]  be_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic [1:0]  slow_i,
    output logic             gnt_o,
    output logic      [31:0] rdata_o
);
    logic [7:0]  mem [0:1023];
    logic [1:0]  wait_q;
    logic [31:0] noise_q = 32'h0000_00A5;
    logic [9:0]  a;
    assign a = {addr_i[9:2], 2'b00};
    // off grant the bus carries a moving pattern, so stale data never matches
    assign rdata_o = gnt_o ? {mem[a+3], mem[a+2], mem[a+1], mem[a]} : noise_q;
    // grant after slow_i waiting cycles, one cycle wide
    always @(posedge clk_i) begin
        noise_q <= {noise_q[30:0], ~noise_q[31]};
        if (rst_i || gnt_o) begin
            gnt_o  <= 1'b0;
            wait_q <= 2'h0;
        end else if (req_i && wait_q < slow_i) begin
            wait_q <= wait_q + 2'h1;
        end else if (req_i) begin
            gnt_o <= 1'b1;
            for (int i = 0; i < 4; i++) begin
                if (we_i && be_i[i]) mem[a + 10'(i)] <= wdata_i[8*i +: 8];
            end
        end
    end
endmodule : sdma_mem_model

// ---- tb/tb_serial_peripheral_dma_channels.sv ----
// self-checking bench for the eight transfer channels
`timescale 1ns/1ps
`include "sdma_consts.svh"
module tb_serial_peripheral_dma_channels;
    logic        clk_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0, gnt, mreq, mwe;
    logic [31:0] reg_addr_i = '0, reg_wdata_i = '0, reg_rdata_o, rdata, maddr, mwdata;
    logic [31:0] seed = 32'h0000_8D3D;
    logic [3:0]  item_half_i = '0, rx_rdy_i = '0, tx_empty_i = '0, rx_take_o, tx_load_o, rx_end_o, tx_end_o, mbe;
    logic [63:0] rx_data_i = '0;
    logic [15:0] tx_data_o;
    logic [1:0]  slow = '0;
    logic [31:0] base [4] = '{`SDMA_BASE_SER0, `SDMA_BASE_SER1, `SDMA_BASE_SER2, `SDMA_BASE_SPI};
    logic [13:0] ofs [5] = '{`SDMA_OFS_RX_PTR, `SDMA_OFS_RX_CNT, `SDMA_OFS_TX_PTR, `SDMA_OFS_TX_CNT,
                             `SDMA_OFS_EN_STAT};
    int          fails = 0, compares = 0;

    always #25 clk_i = ~clk_i;

    sdma_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .item_half_i(item_half_i), .rx_rdy_i(rx_rdy_i), .rx_data_i(rx_data_i), .rx_take_o(rx_take_o),
        .tx_empty_i(tx_empty_i), .tx_data_o(tx_data_o), .tx_load_o(tx_load_o), .rx_end_o(rx_end_o),
        .tx_end_o(tx_end_o), .mem_req_o(mreq), .mem_we_o(mwe), .mem_addr_o(maddr), .mem_be_o(mbe),
        .mem_wdata_o(mwdata), .mem_gnt_i(gnt), .mem_rdata_i(rdata));
    sdma_mem_model mem_u (.clk_i(clk_i), .rst_i(rst_i), .req_i(mreq), .we_i(mwe), .addr_i(maddr),
        .be_i(mbe), .wdata_i(mwdata), .slow_i(slow), .gnt_o(gnt), .rdata_o(rdata));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // pointer after n items of one or two bytes
    function automatic logic [31:0] nxt(input logic [31:0] a, n, input logic hf);
        return a + (hf ? n << 1 : n);
    endfunction : nxt

    task automatic check(input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic results();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : results

    // one write strobe, released at the edge that takes it
    task automatic wr(input logic [31:0] a, d);
        @(posedge clk_i);
        reg_wr_i    <= 1'b1;
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr

    // read data stands only in the cycle after the strobe
    task automatic rchk(input logic [31:0] a, exp);
        @(posedge clk_i);
        reg_rd_i   <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1 check(reg_rdata_o, exp);
    endtask : rchk

    // bounded wait: 0 take, 1 load, 2 rx end, 3 tx end
    task automatic wait_on(input int s, i);
        logic [3:0] v;
        int         k;
        k = 0;
        do begin
            @(negedge clk_i);
            v = {tx_end_o[i], rx_end_o[i], tx_load_o[i], rx_take_o[i]};
            k++;
        end while (v[s] !== 1'b1 && k < 40);
        check(k < 40, 1);
    endtask : wait_on

    // receive on port p and transmit on port q at once
    task automatic xfer(input int p, q, input logic hf);
        logic [31:0] r, rp, tp, n, e;
        logic [15:0] dat [4];
        r    = rnd();
        rp   = {24'h0, r[6:1], 2'b00}; // keeps both regions inside the model
        tp   = rp + 32'h200;
        n    = {30'h0, r[9:8]} + 32'h1;
        slow = r[11:10];
        @(posedge clk_i);
        item_half_i <= {4{hf}} & (4'(1 << p) | 4'(1 << q));
        wr(base[p] + `SDMA_OFS_RX_PTR, rp);
        wr(base[p] + `SDMA_OFS_RX_CNT, n);
        wr(base[q] + `SDMA_OFS_TX_PTR, tp);
        wr(base[q] + `SDMA_OFS_TX_CNT, n);
        wr(base[p] + `SDMA_OFS_EN_SET, 32'h1);
        wr(base[q] + `SDMA_OFS_EN_SET, 32'h2);
        repeat (3) @(negedge clk_i) check({rx_take_o[p], mreq}, 0);
        fork
            for (int i = 0; i < n; i++) begin
                dat[i] = 16'(rnd());
                @(posedge clk_i);
                rx_rdy_i[p]           <= 1'b1;
                rx_data_i[16*p +: 16] <= dat[i];
                wait_on(0, p);
                @(posedge clk_i);
                rx_rdy_i[p]           <= 1'b0;
                rx_data_i[16*p +: 16] <= ~dat[i];
            end
            for (int i = 0; i < n; i++) begin
                @(posedge clk_i);
                tx_empty_i[q] <= 1'b1;
                wait_on(1, q);
                e = hf ? {mem_u.mem[tp+2*i+1], mem_u.mem[tp+2*i]} : mem_u.mem[tp+i];
                check(hf ? tx_data_o : tx_data_o[7:0], e);
                @(posedge clk_i);
                tx_empty_i[q] <= 1'b0;
                repeat (slow) @(posedge clk_i);
            end
        join
        wait_on(2, p);
        wait_on(3, q);
        // ports keep offering: a finished channel must stay quiet
        @(posedge clk_i);
        rx_rdy_i[p]   <= 1'b1;
        tx_empty_i[q] <= 1'b1;
        repeat (4) @(negedge clk_i) check({rx_take_o[p], tx_load_o[q], mreq}, 0);
        @(posedge clk_i);
        rx_rdy_i[p]   <= 1'b0;
        tx_empty_i[q] <= 1'b0;
        for (int i = 0; i < n; i++) begin
            e = hf ? {mem_u.mem[rp+2*i+1], mem_u.mem[rp+2*i]} : mem_u.mem[rp+i];
            check(e, hf ? dat[i] : dat[i][7:0]);
        end
        rchk(base[p] + `SDMA_OFS_RX_PTR, nxt(rp, n, hf));
        rchk(base[p] + `SDMA_OFS_RX_CNT, 0);
        rchk(base[q] + `SDMA_OFS_TX_PTR, nxt(tp, n, hf));
        wr(base[p] + `SDMA_OFS_EN_CLR, 32'h3);
        wr(base[q] + `SDMA_OFS_EN_CLR, 32'h3);
        @(negedge clk_i) check({rx_end_o[p], tx_end_o[q]}, 0);
        $display("transfer rx %0d tx %0d half %0d done", p, q, hf);
    endtask : xfer

    // main sequence: reset, register map, then transfers
    initial begin
        logic [31:0] r;
        for (int i = 0; i < 1024; i++) mem_u.mem[i] = 8'(rnd());
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int p = 0; p < 4; p++) begin
            for (int o = 0; o < 5; o++) rchk(base[p] + ofs[o], 0);
            wr(base[p] + `SDMA_OFS_EN_SET, 32'h1);
            rchk(base[p] + `SDMA_OFS_EN_STAT, 32'h1);
            wr(base[p] + `SDMA_OFS_EN_SET, 32'h2);
            rchk(base[p] + `SDMA_OFS_EN_STAT, 32'h3);
            wr(base[p] + `SDMA_OFS_EN_CLR, 32'h1);
            rchk(base[p] + `SDMA_OFS_EN_STAT, 32'h2);
            wr(base[p] + `SDMA_OFS_EN_CLR, 32'h0);
            rchk(base[p] + `SDMA_OFS_EN_STAT, 32'h2);
            wr(base[p] + `SDMA_OFS_EN_CLR, 32'h2);
            r = rnd();
            wr(base[p] + `SDMA_OFS_RX_PTR, r);
            rchk(base[p] + `SDMA_OFS_RX_PTR, r);
            wr(base[p] + `SDMA_OFS_TX_CNT, r);
            rchk(base[p] + `SDMA_OFS_TX_CNT, {16'h0, r[15:0]});
            rchk(base[p] + 14'h004C, 0);
        end
        rchk(32'hFFFB_8030, 0);
        rchk(32'h0000_0030, 0);
        $display("register map tests done");
        for (int t = 0; t < 8; t++) xfer(t % 4, (t + 1) % 4, t >= 4);
        xfer(2, 2, 1'b1);
        results();
    end

    // watchdog well past the expected run length
    initial begin
        repeat (30000) @(posedge clk_i);
        fails++;
        results();
    end
endmodule : tb_serial_peripheral_dma_channels
